// ---- tb.sv ----
// tb.sv: self-checking bench of the uart status block
// assumes usf_uart, usf_line_node and the package in one folder
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  usf_pkg::usf_req_s regReq = '0;
  logic linRx, gpioRx, uartTxd, uartIrq;
  logic [15:0] regRdData;
  logic [15:0] expQ[$];
  logic [15:0] mskQ[$];
  logic rdLast = 1'b0;
  int mismatches = 0;
  int testsRun = 0;
  int seed = 68;
  int n, lows;
  logic [31:0] v;
  logic [7:0] b, b2, d1, d2;
  logic [15:0] fdivTab[3] = '{16'h8000, 16'h8c00, 16'h0000};
  int lenTab[3] = '{1152, 432, 288};
  logic [7:0] srcTab[4] = '{8'h00, 8'h80, 8'h40, 8'hc0};

  usf_uart usf_uart_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regReq(regReq),
    .linRx(linRx), .gpioRx(gpioRx), .regRdData(regRdData), .uartTxd(uartTxd), .uartIrq(uartIrq));
  usf_line_node #(.BIT_CLKS(32)) usf_line_node_i (.sys_clk(sys_clk), .uartTxd(uartTxd),
    .linRx(linRx), .gpioRx(gpioRx));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus cycle at offset o; hold keeps strobes for a back-to-back access
  task automatic acc(input logic rd, input logic [7:0] o, input logic [15:0] d, input bit hold);
    regReq.addr <= {24'hffff07, o};
    regReq.wdata <= d;
    regReq.rd <= rd;
    regReq.wr <= !rd;
    @(posedge sys_clk);
    if (!hold) begin
      regReq.rd <= 1'b0;
      regReq.wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [15:0] d);
    acc(1'b0, o, d, 1'b0);
  endtask
  // read with the expected value noted for the watcher
  task automatic rdx(input logic [7:0] o, input logic [15:0] e, input logic [15:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    acc(1'b1, o, 16'h0000, 1'b0);
  endtask

  // read data stands only in the cycle after the read strobe
  always @(posedge sys_clk) begin
    if (rdLast && mskQ.size() > 0) begin
      if (mskQ[0] != 16'h0000) check("read data", regRdData & mskQ[0], expQ[0] & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
    rdLast <= regReq.rd;
  end

  // length of the low stretch of the next transmit frame
  task automatic txLow(output int c);
    c = 0;
    for (int i = 0; i < 400 && uartTxd === 1'b1; i++) @(posedge sys_clk);
    while (uartTxd === 1'b0 && c < 3000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rdx(8'h14, 16'h0060, 16'h00ff);
    rdx(8'h08, 16'h0001, 16'h00ff);
    rdx(8'h04, 16'h0000, 16'h00ff);
    rdx(8'h10, 16'h0000, 16'h00ff);
    rdx(8'h2c, 16'h0000, 16'hffff);
    check("irq", uartIrq, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      wr(8'h2c, v[15:0] & 16'h9fff);
      rdx(8'h2c, v[15:0] & 16'h9fff, 16'hffff);
      wr(8'h04, {8'h00, v[23:16]});
      rdx(8'h04, {13'h0000, v[18:16]}, 16'h00ff);
      wr(8'h10, {8'h00, v[31:24]});
      rdx(8'h10, {8'h00, v[31:24] & 8'hd0}, 16'h00ff);
    end
    wr(8'h04, 16'h0000);
    wr(8'h10, 16'h0000);
    rdx(8'h08, 16'h0000, 16'h0000);
    wr(8'h14, 16'h00ff);
    rdx(8'h14, 16'h0060, 16'h00ff);
    rdx(8'h20, 16'h0000, 16'hffff);
    wr(8'h0c, 16'h0003);
    // bit time of integer and fractional generators
    for (int k = 0; k < 3; k++) begin
      wr(8'h2c, fdivTab[k]);
      fork
        wr(8'h00, 16'h0000);
        txLow(n);
      join
      check("low span", n[15:0], lenTab[k][15:0]);
      repeat (200) @(posedge sys_clk);
    end
    // holding and shift flags with two frames back to back
    v = $random(seed);
    fork
      begin
        acc(1'b0, 8'h00, {8'h00, v[7:0]}, 1'b1);
        rdx(8'h14, 16'h0000, 16'h0060);
        rdx(8'h14, 16'h0020, 16'h0060);
        acc(1'b0, 8'h00, {8'h00, v[15:8]}, 1'b1);
        rdx(8'h14, 16'h0000, 16'h0060);
      end
      begin
        usf_line_node_i.getTx(d1);
        usf_line_node_i.getTx(d2);
      end
    join
    check("tx data", {d2, d1}, v[15:0]);
    repeat (60) @(posedge sys_clk);
    rdx(8'h14, 16'h0060, 16'h0060);
    // loopback holds the transmit pin high
    wr(8'h10, 16'h0010);
    lows = 0;
    fork
      wr(8'h00, {8'h00, v[23:16]});
      repeat (400) begin
        @(posedge sys_clk);
        if (uartTxd !== 1'b1) lows++;
      end
    join
    check("loop txd lows", lows[15:0], 16'h0000);
    rdx(8'h14, 16'h0001, 16'h0001);
    rdx(8'h00, {8'h00, v[23:16]}, 16'h00ff);
    // receive source codes, both lines carrying different bytes
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, {8'h00, srcTab[k]});
      v = $random(seed);
      b = v[7:0];
      fork
        usf_line_node_i.send(1'b0, b, 1'b0, 1'b0, 1'b1);
        usf_line_node_i.send(1'b1, ~b, 1'b0, 1'b0, 1'b1);
      join
      rdx(8'h14, {15'h0000, ~srcTab[k][6]}, 16'h0001);
      rdx(8'h00, {8'h00, srcTab[k][7] ? ~b : b}, srcTab[k][6] ? 16'h0000 : 16'h00ff);
      rdx(8'h14, 16'h0000, 16'h0001);
    end
    wr(8'h10, 16'h0000);
    // overrun and identification priorities
    wr(8'h04, 16'h0001);
    usf_line_node_i.send(1'b0, v[15:8], 1'b0, 1'b0, 1'b1);
    rdx(8'h08, 16'h0004, 16'h00ff);
    check("irq", uartIrq, 16'h0001);
    b2 = v[23:16];
    usf_line_node_i.send(1'b0, b2, 1'b0, 1'b0, 1'b1);
    rdx(8'h08, 16'h0004, 16'h00ff);
    wr(8'h04, 16'h0007);
    rdx(8'h08, 16'h0006, 16'h00ff);
    rdx(8'h14, 16'h0063, 16'h00ff);
    rdx(8'h08, 16'h0004, 16'h00ff);
    rdx(8'h00, {8'h00, b2}, 16'h00ff);
    rdx(8'h08, 16'h0002, 16'h00ff);
    rdx(8'h08, 16'h0001, 16'h00ff);
    repeat (2) @(posedge sys_clk);
    check("irq", uartIrq, 16'h0000);
    // parity: good then bad, odd parity
    wr(8'h04, 16'h0000);
    wr(8'h0c, 16'h000b);
    usf_line_node_i.send(1'b0, b2, 1'b1, ~^b2, 1'b1);
    rdx(8'h14, 16'h0000, 16'h0004);
    rdx(8'h00, 16'h0000, 16'h0000);
    usf_line_node_i.send(1'b0, b2, 1'b1, ^b2, 1'b1);
    wr(8'h04, 16'h0004);
    rdx(8'h08, 16'h0006, 16'h00ff);
    rdx(8'h14, 16'h0004, 16'h0004);
    rdx(8'h08, 16'h0001, 16'h00ff);
    rdx(8'h00, 16'h0000, 16'h0000);
    // invalid stop bit, then a break
    wr(8'h04, 16'h0000);
    wr(8'h0c, 16'h0003);
    usf_line_node_i.send(1'b0, b2, 1'b0, 1'b0, 1'b0);
    rdx(8'h14, 16'h0008, 16'h0008);
    rdx(8'h00, 16'h0000, 16'h0000);
    usf_line_node_i.brk(16);
    rdx(8'h14, 16'h0010, 16'h0010);
    rdx(8'h14, 16'h0000, 16'h001e);
    // a write taken while the clock enable is low must be lost
    clkEn <= 1'b0;
    wr(8'h04, 16'h0007);
    clkEn <= 1'b1;
    rdx(8'h04, 16'h0000, 16'h00ff);
    repeat (4) @(posedge sys_clk);
    final_report();
  end
endmodule
`default_nettype wire

// ---- usf_defines.svh ----
// usf_defines.svh: offsets, field positions, reset values and timing counts of the uart status block
// assumes a byte-addressed register port with 16-bit data; included by bare name
`ifndef USF_DEFINES_SVH
`define USF_DEFINES_SVH
`define USF_ADDR_DATA 32'hffff0700
`define USF_ADDR_IEN 32'hffff0704
`define USF_ADDR_IID 32'hffff0708
`define USF_ADDR_LCR 32'hffff070c
`define USF_ADDR_CON1 32'hffff0710
`define USF_ADDR_LSR 32'hffff0714
`define USF_ADDR_FDIV 32'hffff072c
`define USF_LCR_DIVISOR_ACCESS_SELECT 7
`define USF_LCR_BRK 6
`define USF_LCR_SP 5
`define USF_LCR_EPS 4
`define USF_LCR_PEN 3
`define USF_LCR_STOP 2
`define USF_CON1_LOOP 4
`define USF_FDIV_FRACTIONAL_GEN_ENABLE 15
`define USF_LSR_RESET 8'h60
`define USF_IID_RESET 8'h01
`define USF_IID_LS 8'h06
`define USF_IID_RX 8'h04
`define USF_IID_TX 8'h02
`define USF_RXSEL_LIN 2'h0
`define USF_RXSEL_GPIO 2'h2
`define USF_BRK_TICKS 8'hc0
`define USF_FRAC_ONE 15'h0800
`define USF_INT_THRESH 15'h1000
`define USF_HALF_BIT 9'h008
`define USF_FULL_BIT 9'h010
`endif

// ---- usf_line_node.sv ----
// usf_line_node.sv: remote serial node on the lin and gpio receive lines
// assumes the bench clock and BIT_CLKS system clocks per bit
`timescale 1ns/100ps
`default_nettype none
module usf_line_node #(
  parameter int BIT_CLKS = 32
) (
  input wire logic sys_clk,
  input wire logic uartTxd,
  output logic linRx,
  output logic gpioRx
);
  // both lines pulled up while idle
  initial begin
    linRx = 1'b1;
    gpioRx = 1'b1;
  end
  // drive a level on one line for n bit times
  task automatic hold(input bit g, input logic lv, input int n);
    if (g) gpioRx <= lv;
    else linRx <= lv;
    repeat (n * BIT_CLKS) @(posedge sys_clk);
  endtask
  // one frame lsb first; parity and stop levels chosen by caller
  task automatic send(input bit g, input logic [7:0] d, input bit pen, input logic pb, input logic sb);
    hold(g, 1'b0, 1);
    for (int i = 0; i < 8; i++) hold(g, d[i], 1);
    if (pen) hold(g, pb, 1);
    hold(g, sb, 1);
    hold(g, 1'b1, 1);
  endtask
  // lin line low for n bit times, then idle
  task automatic brk(input int n);
    hold(1'b0, 1'b0, n);
    hold(1'b0, 1'b1, 2);
  endtask
  // capture one 8-bit frame, sampled mid bit, ends inside the stop bit
  task automatic getTx(output logic [7:0] d);
    int w;
    w = 0;
    while (uartTxd !== 1'b0 && w < 3000) begin
      @(posedge sys_clk);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      d[i] = uartTxd;
    end
    repeat (BIT_CLKS) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- usf_pkg.sv ----
// usf_pkg.sv: types of the uart status block
// assumes nothing beyond a systemverilog compiler
package usf_pkg;
  // receiver states, one-hot
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } usf_rx_e;

  // one register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } usf_req_s;

  // whole state of the block
  typedef struct packed {
    logic [2:0] ien;
    logic [7:0] lcr;
    logic [1:0] rxSel;
    logic loop;
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [15:0] fdiv;
    logic [7:0] thr;
    logic thrFull;
    logic txBusy;
    logic [11:0] txShift;
    logic [8:0] txCnt;
    logic [8:0] txTotal;
    logic txOut;
    usf_rx_e rxState;
    logic [3:0] rxSub;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxPerr;
    logic [7:0] rxHold;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic txIntPend;
    logic [7:0] brkCnt;
    logic [15:0] preCnt;
    logic [14:0] fracAcc;
    logic tick;
    logic [15:0] rdData;
    logic irq;
  } usf_state_s;
endpackage

// ---- usf_uart.sv ----
// usf_uart.sv: uart registers, line status, interrupt identification, fractional baud and serial engine
// assumes synchronous serial inputs, a plain register port and one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "usf_defines.svh"

module usf_uart (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire usf_pkg::usf_req_s regReq,
  input wire logic linRx,
  input wire logic gpioRx,
  output logic [15:0] regRdData,
  output logic uartTxd,
  output logic uartIrq
);

  usf_pkg::usf_state_s st;
  usf_pkg::usf_state_s next_st;
  logic [7:0] lsr;
  logic [7:0] iid;
  logic lsInt;
  logic rxInt;
  logic txInt;
  logic rxLine;
  logic [14:0] thresh;
  logic divisor_access_select;

  // line status and identification views of the state
  assign lsr = {1'b0, ~st.thrFull & ~st.txBusy, ~st.thrFull, st.bi, st.fe, st.pe, st.oe, st.dr};
  assign lsInt = st.ien[2] & (st.fe | st.pe | st.oe);
  assign rxInt = st.ien[0] & st.dr;
  assign txInt = st.ien[1] & st.txIntPend;
  assign iid = lsInt ? `USF_IID_LS : rxInt ? `USF_IID_RX : txInt ? `USF_IID_TX : `USF_IID_RESET;
  assign divisor_access_select = st.lcr[`USF_LCR_DIVISOR_ACCESS_SELECT];

  // receive source selection; reserved codes leave the line idle
  always_comb begin
    if (st.loop) begin
      rxLine = st.txBusy ? st.txShift[0] : 1'b1;
    end else if (st.rxSel == `USF_RXSEL_LIN) begin
      rxLine = linRx;
    end else if (st.rxSel == `USF_RXSEL_GPIO) begin
      rxLine = gpioRx;
    end else begin
      rxLine = 1'b1;
    end
  end

  // oversample period in units of 1/2048 divisor periods
  always_comb begin
    logic [2:0] mVal;
    mVal = (st.fdiv[12:11] == 2'h0) ? 3'h4 : {1'b0, st.fdiv[12:11]};
    if (st.fdiv[`USF_FDIV_FRACTIONAL_GEN_ENABLE]) begin
      thresh = {mVal, st.fdiv[10:0], 1'b0};
    end else begin
      thresh = `USF_INT_THRESH;
    end
  end

  // next state of the whole block
  always_comb begin
    logic [15:0] dl;
    logic [14:0] accSum;
    logic [3:0] wlen;
    logic [7:0] dataMasked;
    logic [8:0] d9;
    logic parBit;
    logic [3:0] nb;
    logic [8:0] extra;
    logic wrThr;
    logic rdRx;
    logic rdLsr;
    logic rdIid;
    logic rxDone;
    logic txLoad;
    dl = 16'h0;
    accSum = 15'h0;
    wlen = 4'h0;
    dataMasked = 8'h0;
    d9 = 9'h0;
    parBit = 1'b0;
    nb = 4'h0;
    extra = 9'h0;
    rxDone = 1'b0;
    txLoad = 1'b0;
    next_st = st;
    wrThr = regReq.wr && regReq.addr == `USF_ADDR_DATA && !divisor_access_select;
    rdRx = regReq.rd && regReq.addr == `USF_ADDR_DATA && !divisor_access_select;
    rdLsr = regReq.rd && regReq.addr == `USF_ADDR_LSR;
    rdIid = regReq.rd && regReq.addr == `USF_ADDR_IID;
    wlen = 4'h5 + {2'h0, st.lcr[1:0]};

    // baud prescaler, then fractional accumulator giving the 16x tick
    dl = ({st.divHigh, st.divLow} == 16'h0) ? 16'h1 : {st.divHigh, st.divLow};
    next_st.tick = 1'b0;
    if (st.preCnt >= dl - 16'h1) begin
      next_st.preCnt = 16'h0;
      accSum = st.fracAcc + `USF_FRAC_ONE;
      if (accSum >= thresh) begin
        next_st.tick = 1'b1;
        next_st.fracAcc = accSum - thresh;
      end else begin
        next_st.fracAcc = accSum;
      end
    end else begin
      next_st.preCnt = st.preCnt + 16'h1;
    end

    // transmitter: move holding register into the shifter on a tick so the start bit lasts a full 16 ticks
    if (!st.txBusy && st.thrFull && st.tick) begin
      txLoad = 1'b1;
      dataMasked = st.thr | (8'hff << wlen);
      parBit = st.lcr[`USF_LCR_SP] ? st.lcr[`USF_LCR_EPS] : (^(st.thr & ~(8'hff << wlen))) ^ ~st.lcr[`USF_LCR_EPS];
      d9 = {1'b1, dataMasked};
      if (st.lcr[`USF_LCR_PEN]) begin
        d9[wlen] = parBit;
      end
      nb = wlen + 4'h2 + {3'h0, st.lcr[`USF_LCR_PEN]};
      if (st.lcr[`USF_LCR_STOP]) begin
        extra = (st.lcr[1:0] == 2'h0) ? `USF_HALF_BIT : `USF_FULL_BIT;
      end
      next_st.txShift = {2'h3, d9, 1'b0};
      next_st.txTotal = {1'b0, nb, 4'h0} + extra;
      next_st.txCnt = 9'h0;
      next_st.txBusy = 1'b1;
      next_st.thrFull = 1'b0;
    end else if (st.txBusy && st.tick) begin
      next_st.txCnt = st.txCnt + 9'h1;
      if (st.txCnt[3:0] == 4'hf) begin
        next_st.txShift = {1'b1, st.txShift[11:1]};
      end
      if (st.txCnt + 9'h1 == st.txTotal) begin
        next_st.txBusy = 1'b0;
      end
    end

    // transmit output, loopback holds it high
    if (st.loop) begin
      next_st.txOut = 1'b1;
    end else if (st.lcr[`USF_LCR_BRK]) begin
      next_st.txOut = 1'b0;
    end else begin
      next_st.txOut = next_st.txBusy ? next_st.txShift[0] : 1'b1;
    end

    // receiver sampling at mid bit
    if (st.tick) begin
      next_st.rxSub = st.rxSub + 4'h1;
      case (st.rxState)
        usf_pkg::RX_IDLE: begin
          next_st.rxSub = 4'h0;
          if (!rxLine) begin
            next_st.rxState = usf_pkg::RX_START;
          end
        end
        usf_pkg::RX_START: begin
          if (st.rxSub == 4'h7) begin
            next_st.rxSub = 4'h0;
            next_st.rxBit = 4'h0;
            next_st.rxPar = 1'b0;
            next_st.rxShift = 8'h0;
            next_st.rxState = rxLine ? usf_pkg::RX_IDLE : usf_pkg::RX_DATA;
          end
        end
        usf_pkg::RX_DATA: begin
          if (st.rxSub == 4'hf) begin
            next_st.rxShift = {rxLine, st.rxShift[7:1]};
            next_st.rxPar = st.rxPar ^ rxLine;
            next_st.rxBit = st.rxBit + 4'h1;
            if (st.rxBit == wlen - 4'h1) begin
              next_st.rxState = st.lcr[`USF_LCR_PEN] ? usf_pkg::RX_PAR : usf_pkg::RX_STOP;
              next_st.rxPerr = 1'b0;
            end
          end
        end
        usf_pkg::RX_PAR: begin
          if (st.rxSub == 4'hf) begin
            if (st.lcr[`USF_LCR_SP]) begin
              next_st.rxPerr = rxLine != st.lcr[`USF_LCR_EPS];
            end else begin
              next_st.rxPerr = rxLine != (st.rxPar ^ ~st.lcr[`USF_LCR_EPS]);
            end
            next_st.rxState = usf_pkg::RX_STOP;
          end
        end
        usf_pkg::RX_STOP: begin
          if (st.rxSub == 4'hf) begin
            rxDone = 1'b1; // only the first stop bit is looked at
            next_st.rxState = usf_pkg::RX_IDLE;
          end
        end
        default: begin
          next_st.rxState = usf_pkg::RX_IDLE;
        end
      endcase
      // break: line low for longer than the longest frame
      if (!rxLine) begin
        if (st.brkCnt != `USF_BRK_TICKS) begin
          next_st.brkCnt = st.brkCnt + 8'h1;
        end
      end else begin
        next_st.brkCnt = 8'h0;
      end
    end

    // line status flags: a set in the same cycle beats a read clear
    next_st.dr = (st.dr & ~rdRx) | rxDone;
    next_st.oe = (st.oe & ~rdLsr) | (rxDone & st.dr & ~rdRx);
    next_st.fe = (st.fe & ~rdLsr) | (rxDone & ~rxLine);
    next_st.pe = (st.pe & ~rdLsr) | (rxDone & st.rxPerr);
    next_st.bi = (st.bi & ~rdLsr) | (st.tick & ~rxLine & st.brkCnt == `USF_BRK_TICKS - 8'h1);
    if (rxDone) begin
      next_st.rxHold = st.rxShift >> (4'h8 - wlen);
    end

    // register writes
    if (regReq.wr) begin
      case (regReq.addr)
        `USF_ADDR_DATA: begin
          if (divisor_access_select) begin
            next_st.divLow = regReq.wdata[7:0];
          end else begin
            next_st.thr = regReq.wdata[7:0];
            next_st.thrFull = 1'b1;
          end
        end
        `USF_ADDR_IEN: begin
          if (divisor_access_select) begin
            next_st.divHigh = regReq.wdata[7:0];
          end else begin
            next_st.ien = regReq.wdata[2:0];
          end
        end
        `USF_ADDR_LCR: next_st.lcr = regReq.wdata[7:0];
        `USF_ADDR_CON1: begin
          next_st.rxSel = regReq.wdata[7:6];
          next_st.loop = regReq.wdata[`USF_CON1_LOOP];
        end
        `USF_ADDR_FDIV: next_st.fdiv = {regReq.wdata[15], 2'h0, regReq.wdata[12:0]};
        default: next_st.ien = next_st.ien;
      endcase
    end

    // transmit empty interrupt: set on emptying or enabling, cleared by write or ident read
    if ((txLoad && !wrThr) || (regReq.wr && regReq.addr == `USF_ADDR_IEN && !divisor_access_select && regReq.wdata[1] && !st.thrFull)) begin
      next_st.txIntPend = 1'b1;
    end else if (wrThr || (rdIid && iid == `USF_IID_TX)) begin
      next_st.txIntPend = 1'b0;
    end

    // register reads, data valid only in the following cycle
    next_st.rdData = 16'h0;
    if (regReq.rd) begin
      case (regReq.addr)
        `USF_ADDR_DATA: next_st.rdData = {8'h0, divisor_access_select ? st.divLow : st.rxHold};
        `USF_ADDR_IEN: next_st.rdData = {8'h0, divisor_access_select ? st.divHigh : {5'h0, st.ien}};
        `USF_ADDR_IID: next_st.rdData = {8'h0, iid};
        `USF_ADDR_LCR: next_st.rdData = {8'h0, st.lcr};
        `USF_ADDR_CON1: next_st.rdData = {8'h0, st.rxSel, 1'b0, st.loop, 4'h0};
        `USF_ADDR_LSR: next_st.rdData = {8'h0, lsr};
        `USF_ADDR_FDIV: next_st.rdData = st.fdiv;
        default: next_st.rdData = 16'h0;
      endcase
    end

    // interrupt output follows the identification
    next_st.irq = ~iid[0];
  end

  // state register with clock enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.txOut <= 1'b1;
      st.rxState <= usf_pkg::RX_IDLE;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign regRdData = st.rdData;
  assign uartTxd = st.txOut;
  assign uartIrq = st.irq;

  // checks on the documented behaviour
  a_loop_tx_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && st.loop |=> uartTxd) else $error("loopback did not hold transmit high");
  a_thr_write_transmitter_idle_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && regReq.wr && regReq.addr == `USF_ADDR_DATA && !divisor_access_select |=> !lsr[6]) else $error("idle flag stayed set");
  a_holding_empty_flag_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && regReq.wr && regReq.addr == `USF_ADDR_DATA && !divisor_access_select |=> !lsr[5] ##1 (lsr[5] || !clkEn || st.thrFull))
    else $error("holding empty flag wrong after write");
  a_lsr_reset_val: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> lsr == `USF_LSR_RESET && iid == `USF_IID_RESET) else $error("status reset value wrong");
  a_dr_read_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && regReq.rd && regReq.addr == `USF_ADDR_DATA && !divisor_access_select && !(st.tick && st.rxState == usf_pkg::RX_STOP)
    |=> !st.dr) else $error("data ready not cleared by read");
  a_ls_priority: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st.ien[2] && (lsr[3] || lsr[2] || lsr[1]) |-> iid == `USF_IID_LS) else $error("line status not top priority");
  a_rx_priority: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !lsInt && st.ien[0] && lsr[0] |-> iid == `USF_IID_RX) else $error("receive full not reported");
  a_iid_tx_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && regReq.rd && regReq.addr == `USF_ADDR_IID && iid == `USF_IID_TX && st.txBusy |=> !st.txIntPend)
    else $error("ident read did not clear transmit interrupt");
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn |=> uartIrq == !$past(iid[0])) else $error("interrupt output disagrees with ident");
  a_int_divisor: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st.fdiv[`USF_FDIV_FRACTIONAL_GEN_ENABLE] |-> thresh == `USF_INT_THRESH) else $error("integer mode period wrong");
  a_rx_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st.loop && st.rxSel[0] |-> rxLine) else $error("reserved source not idle");

endmodule
`default_nettype wire
